// ==== fcd_decoder.sv ====
// Floating-point, extended floating-point and second-coprocessor field decoder.
`timescale 1ns/1ns
module fcd_decoder (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [31:0]  instr_word,
  input  wire logic         instr_valid,
  input  wire logic         fp64_en,
  input  wire logic         fp_usable,
  input  wire logic         cp2_usable,
  input  wire logic         cp2_present,
  output logic              dec_valid_q,
  output fcd_pkg::fcd_cls_e dec_class_q,
  output logic [5:0]        dec_op_q,
  output fcd_pkg::fcd_fmt_e dec_fmt_q,
  output logic              dec_flag_sel_q,
  output logic              reserved_instr_q,
  output logic              cop_unusable_q
);
  logic [31:0]       word_q;
  logic              wvalid_q;
  logic [5:0]        opc;
  logic [4:0]        sel;
  logic [5:0]        fn;
  logic [2:0]        fn_row;
  logic [2:0]        fn_col;
  fcd_pkg::fcd_fmt_e sel_fmt;
  logic              sel_fmt_res;
  fcd_pkg::fcd_fmt_e x_fmt;
  logic              x_fmt_res;
  fcd_pkg::fcd_cls_e cls_d;
  logic [5:0]        op_d;
  fcd_pkg::fcd_fmt_e fmt_d;
  logic              flag_sel_d;
  logic              res_d;
  logic              unus_d;
  logic              valid_d;

  assign opc    = word_q[fcd_pkg::OPC_HI:fcd_pkg::OPC_LO];
  assign sel    = word_q[fcd_pkg::SEL_HI:fcd_pkg::SEL_LO];
  assign fn     = word_q[fcd_pkg::FN_HI:fcd_pkg::FN_LO];
  assign fn_row = fn[5:3];
  assign fn_col = fn[2:0];

  // The word is held in a register so the decode has a full cycle before the outputs latch.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      word_q   <= fcd_pkg::NOP_WORD;
      wvalid_q <= 1'b0;
    end else begin
      word_q   <= instr_word;
      wvalid_q <= instr_valid;
    end
  end

  fcd_fmt_map u_sel_fmt (
    .code         (sel),
    .is_three_bit (1'b0),
    .fp64_en      (fp64_en),
    .fmt          (sel_fmt),
    .fmt_reserved (sel_fmt_res),
    .fmt_needs64  ()
  );

  fcd_fmt_map u_x_fmt (
    .code         ({2'b00, fn_col}),
    .is_three_bit (1'b1),
    .fp64_en      (fp64_en),
    .fmt          (x_fmt),
    .fmt_reserved (x_fmt_res),
    .fmt_needs64  ()
  );

  always_comb begin
    cls_d   = fcd_pkg::FCD_CLS_NONE;
    op_d    = 6'h00;
    fmt_d   = fcd_pkg::FCD_FMT_S;
    flag_sel_d = 1'b0;
    res_d   = 1'b0;
    unus_d  = 1'b0;
    valid_d = 1'b0;
    if (opc == fcd_pkg::OPC_FP) begin
      valid_d = wvalid_q;
      unus_d  = !fp_usable;
      if (sel < fcd_pkg::SEL_FMT_MIN) begin
        op_d = {1'b0, sel};
        case (sel)
          5'h00, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07: cls_d = fcd_pkg::FCD_CLS_MOVE;
          fcd_pkg::SEL_BRANCH: cls_d = fcd_pkg::FCD_CLS_BRANCH;
          default: res_d = 1'b1;
        endcase
      end else begin
        fmt_d = sel_fmt;
        op_d  = fn;
        res_d = sel_fmt_res;
        case (sel_fmt)
          fcd_pkg::FCD_FMT_S, fcd_pkg::FCD_FMT_D: begin
            if (fn_row == 3'h0 || fn_row == 3'h1) begin
              cls_d = fcd_pkg::FCD_CLS_ARITH;
              // The 64-bit integer conversions exist only with 64-bit FP enabled.
              if (fn_row == 3'h1 && !fn_col[2] && !fp64_en) begin
                res_d = 1'b1;
              end
            end else if (fn_row[2:1] == 2'b11) begin
              cls_d = fcd_pkg::FCD_CLS_CMP;
            end else if (fn == fcd_pkg::FN_CMOV) begin
              cls_d      = fcd_pkg::FCD_CLS_CMOV;
              flag_sel_d = word_q[fcd_pkg::CMOV_BIT];
              op_d       = word_q[fcd_pkg::CMOV_BIT] ? fcd_pkg::OP_MOVT : fcd_pkg::OP_MOVF;
            end else begin
              cls_d = fcd_pkg::FCD_CLS_OTHER;
              res_d = 1'b1;
            end
          end
          fcd_pkg::FCD_FMT_W, fcd_pkg::FCD_FMT_L: begin
            if (fn == fcd_pkg::FN_CVT_S || fn == fcd_pkg::FN_CVT_D
                || fn == fcd_pkg::FN_CVT_PAIR) begin
              cls_d = fcd_pkg::FCD_CLS_CVT;
            end else begin
              res_d = 1'b1;
            end
          end
          fcd_pkg::FCD_FMT_PR: begin
            if (fn == fcd_pkg::FN_CVT_SL || fn[5:2] == fcd_pkg::FN_MERGE_LO[5:2]) begin
              cls_d = fcd_pkg::FCD_CLS_CVT;
            end else if (fn_row[2:1] == 2'b11) begin
              cls_d = fcd_pkg::FCD_CLS_CMP;
            end else if (fn == fcd_pkg::FN_CMOV) begin
              cls_d      = fcd_pkg::FCD_CLS_CMOV;
              flag_sel_d = word_q[fcd_pkg::CMOV_BIT];
              op_d       = word_q[fcd_pkg::CMOV_BIT] ? fcd_pkg::OP_MOVT : fcd_pkg::OP_MOVF;
            end else if (fn_row == 3'h0 && fn_col != 3'h3 && fn_col != 3'h4) begin
              cls_d = fcd_pkg::FCD_CLS_ARITH;
            end else begin
              res_d = 1'b1;
            end
          end
          default: res_d = 1'b1;
        endcase
      end
    end else if (opc == fcd_pkg::OPC_FPX) begin
      valid_d = wvalid_q;
      unus_d  = !fp_usable;
      op_d    = fn;
      case (fn)
        6'h00, 6'h01: cls_d = fcd_pkg::FCD_CLS_LOAD;
        6'h05: begin
          cls_d = fcd_pkg::FCD_CLS_LOAD;
          res_d = !fp64_en;
        end
        6'h08, 6'h09: cls_d = fcd_pkg::FCD_CLS_STORE;
        6'h0D: begin
          cls_d = fcd_pkg::FCD_CLS_STORE;
          res_d = !fp64_en;
        end
        fcd_pkg::FN_PREFETCH: cls_d = fcd_pkg::FCD_CLS_PREF;
        default: begin
          if (fn_row[2]) begin
            cls_d = fcd_pkg::FCD_CLS_MADD;
            fmt_d = x_fmt;
            res_d = x_fmt_res || (x_fmt != fcd_pkg::FCD_FMT_S
                    && x_fmt != fcd_pkg::FCD_FMT_D && x_fmt != fcd_pkg::FCD_FMT_PR);
          end else begin
            res_d = 1'b1;
          end
        end
      endcase
    end else if (opc == fcd_pkg::OPC_CP2) begin
      valid_d = wvalid_q;
      unus_d  = !cp2_usable;
      op_d    = {1'b0, sel};
      // An absent second coprocessor makes every encoding here reserved.
      res_d   = !cp2_present;
      if (sel[4]) begin
        cls_d = fcd_pkg::FCD_CLS_CP2OP;
      end else begin
        case (sel)
          5'h00, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07: cls_d = fcd_pkg::FCD_CLS_MOVE;
          fcd_pkg::SEL_BRANCH: cls_d = fcd_pkg::FCD_CLS_BRANCH;
          default: res_d = 1'b1;
        endcase
      end
    end
    // Unusable takes priority over reserved, matching coprocessor access checks.
    if (unus_d) begin
      res_d = 1'b0;
    end
    if (!valid_d) begin
      res_d  = 1'b0;
      unus_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dec_valid_q      <= 1'b0;
      dec_class_q      <= fcd_pkg::FCD_CLS_NONE;
      dec_op_q         <= 6'h00;
      dec_fmt_q        <= fcd_pkg::FCD_FMT_S;
      dec_flag_sel_q   <= 1'b0;
      reserved_instr_q <= 1'b0;
      cop_unusable_q   <= 1'b0;
    end else begin
      dec_valid_q      <= valid_d;
      dec_class_q      <= cls_d;
      dec_op_q         <= op_d;
      dec_fmt_q        <= fmt_d;
      dec_flag_sel_q   <= flag_sel_d;
      reserved_instr_q <= res_d;
      cop_unusable_q   <= unus_d;
    end
  end
endmodule

// ==== fcd_pkg.sv ====
// Package of field positions, opcodes, formats and operation codes for the FP field decoder.
// Operation
// - Register-select values 0 to 15 are interface operations, never a data format.
// - Format 16 or three-bit 0 means 32-bit single floating point.
// - Format 17 or three-bit 1 means 64-bit double floating point.
// - Format 20 or three-bit 4 means 32-bit fixed-point word.
// - Format 21 or three-bit 5 means 64-bit fixed-point long.
// - Format 22 or three-bit 6 means paired single, two packed 32-bit values.
// - Formats 18, 19, 23 and 24 to 31 are reserved.
// - Long format is legal only while 64-bit FP operations are enabled.
// - Paired single is legal only while 64-bit FP operations are enabled.
// - Conditional move on flag uses bit 16: 0 move-if-false, 1 move-if-true.
// - Select 0,2,3,4,6,7 are the word, control and high-half moves; 1,5 reserved.
// - Single/double functions 0 to 7: add, sub, mul, div, sqrt, abs, mov, neg.
// - Functions 8-11 round/trunc/ceil/floor to 64-bit, 12-15 to 32-bit integer.
// - Single/double functions 48 to 63 are the sixteen compare conditions.
// - Word/long accept only functions 32, 33 and 38; all others reserved.
// - Paired single functions 40, 44-47: convert lower and the four pair merges.
// - 64-bit-only encodings trap reserved when disabled, unusable when inaccessible.
// - Encodings for absent optional modules raise a reserved-instruction exception.
package fcd_pkg;
  localparam int          OPC_HI      = 31;
  localparam int          OPC_LO      = 26;
  localparam int          SEL_HI      = 25;
  localparam int          SEL_LO      = 21;
  localparam int          FN_HI       = 5;
  localparam int          FN_LO       = 0;
  localparam int          CMOV_BIT    = 16;
  localparam logic [5:0]  OPC_FP      = 6'h11;
  localparam logic [5:0]  OPC_CP2     = 6'h12;
  localparam logic [5:0]  OPC_FPX     = 6'h13;
  localparam logic [31:0] NOP_WORD    = 32'h0000_0000;
  localparam logic [4:0]  SEL_FMT_MIN = 5'h10;
  localparam logic [4:0]  SEL_BRANCH  = 5'h08;
  localparam logic [5:0]  FN_CMOV     = 6'h11;
  localparam logic [5:0]  FN_CMP_MIN  = 6'h30;
  localparam logic [5:0]  FN_CVT_S    = 6'h20;
  localparam logic [5:0]  FN_CVT_D    = 6'h21;
  localparam logic [5:0]  FN_CVT_PAIR = 6'h26;
  localparam logic [5:0]  FN_CVT_SL   = 6'h28;
  localparam logic [5:0]  FN_MERGE_LO = 6'h2C;
  localparam logic [5:0]  FN_PREFETCH = 6'h0F;

  typedef enum logic [2:0] {
    FCD_FMT_S  = 3'h0,
    FCD_FMT_D  = 3'h1,
    FCD_FMT_R2 = 3'h2,
    FCD_FMT_R3 = 3'h3,
    FCD_FMT_W  = 3'h4,
    FCD_FMT_L  = 3'h5,
    FCD_FMT_PR = 3'h6,
    FCD_FMT_R7 = 3'h7
  } fcd_fmt_e;

  typedef enum logic [3:0] {
    FCD_CLS_NONE   = 4'h0,
    FCD_CLS_MOVE   = 4'h1,
    FCD_CLS_BRANCH = 4'h2,
    FCD_CLS_ARITH  = 4'h3,
    FCD_CLS_CVT    = 4'h4,
    FCD_CLS_CMP    = 4'h5,
    FCD_CLS_CMOV   = 4'h6,
    FCD_CLS_LOAD   = 4'h7,
    FCD_CLS_STORE  = 4'h8,
    FCD_CLS_PREF   = 4'h9,
    FCD_CLS_MADD   = 4'hA,
    FCD_CLS_CP2OP  = 4'hB,
    FCD_CLS_OTHER  = 4'hC
  } fcd_cls_e;

  // Operation codes inside a class.
  localparam logic [5:0] OP_MFW      = 6'h00;
  localparam logic [5:0] OP_MFC      = 6'h02;
  localparam logic [5:0] OP_MFH      = 6'h03;
  localparam logic [5:0] OP_MTW      = 6'h04;
  localparam logic [5:0] OP_MTC      = 6'h06;
  localparam logic [5:0] OP_MTH      = 6'h07;
  localparam logic [5:0] OP_MOVF     = 6'h00;
  localparam logic [5:0] OP_MOVT     = 6'h01;
endpackage

// ==== fcd_fmt_map.sv ====
// Format-code mapper shared by the register-select and three-bit format fields.
`timescale 1ns/1ns
module fcd_fmt_map (
  input  wire logic [4:0]     code,
  input  wire logic           is_three_bit,
  input  wire logic           fp64_en,
  output fcd_pkg::fcd_fmt_e   fmt,
  output logic                fmt_reserved,
  output logic                fmt_needs64
);
  logic [2:0] low;

  always_comb begin
    low          = code[2:0];
    fmt          = fcd_pkg::fcd_fmt_e'(low);
    fmt_needs64  = 1'b0;
    fmt_reserved = 1'b0;
    // Five-bit codes 24 to 31 have no three-bit twin and are reserved.
    if (!is_three_bit && code[3]) begin
      fmt_reserved = 1'b1;
    end
    case (low)
      3'h0: fmt_reserved = fmt_reserved;
      3'h1: fmt_reserved = fmt_reserved;
      3'h4: fmt_reserved = fmt_reserved;
      3'h5: fmt_needs64  = 1'b1;
      3'h6: fmt_needs64  = 1'b1;
      default: fmt_reserved = 1'b1;
    endcase
    if (fmt_needs64 && !fp64_en) begin
      fmt_reserved = 1'b1;
    end
  end
endmodule

// ==== fcd_fetch_model.sv ====
// Fetch-stage stand-in that presents instruction words to the decoder.
`timescale 1ns/1ns
module fcd_fetch_model (
  input  wire logic   sys_clk,
  output logic [31:0] instr_word,
  output logic        instr_valid
);
  initial begin
    instr_word = 32'h0000_0000;
    instr_valid = 1'b0;
  end
  // An idle slot shows the inverted last word, so stale data never looks valid by accident.
  task automatic send(input logic [31:0] w, input logic v);
    @(posedge sys_clk);
    instr_valid <= v;
    instr_word  <= v ? w : ~instr_word;
  endtask
endmodule

// ==== fcd_decoder_assertions.sv ====
// Port-level checks on the floating-point field decoder.
`timescale 1ns/1ns
module fcd_decoder_chk (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [31:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        fp64_en,
  input wire logic        fp_usable,
  input wire logic        cp2_usable,
  input wire logic        cp2_present,
  input wire logic        dec_valid_q,
  input fcd_pkg::fcd_cls_e dec_class_q,
  input wire logic [5:0]  dec_op_q,
  input fcd_pkg::fcd_fmt_e dec_fmt_q,
  input wire logic        dec_flag_sel_q,
  input wire logic        reserved_instr_q,
  input wire logic        cop_unusable_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire [4:0] sel = instr_word[25:21];
  wire [5:0] fn  = instr_word[5:0];
  wire [5:0] opc = instr_word[31:26];
  wire       fp  = instr_valid && opc == fcd_pkg::OPC_FP;
  wire       any = opc inside {fcd_pkg::OPC_FP, fcd_pkg::OPC_CP2, fcd_pkg::OPC_FPX};
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    !rst_b |=> !dec_valid_q && !reserved_instr_q && !cop_unusable_q)
    else $error("outputs not cleared by reset");
  AST_NON_FP: assert property (
    !(instr_valid && any) |-> ##2 !dec_valid_q && !reserved_instr_q && !cop_unusable_q)
    else $error("foreign or idle word raised a decode");
  AST_SEL_MOVE: assert property (
    fp && sel inside {0, 2, 3, 4, 6, 7} ##0 fp_usable[*3]
    |-> dec_class_q == fcd_pkg::FCD_CLS_MOVE && dec_op_q == {1'b0, $past(sel, 2)})
    else $error("move select decoded wrongly");
  AST_FMT_RSV: assert property (
    fp && (sel inside {18, 19, 23} || sel >= 24) ##0 fp_usable[*3]
    |-> reserved_instr_q && !cop_unusable_q)
    else $error("reserved format not flagged");
  AST_FP64_GATE: assert property (
    fp && sel inside {21, 22} ##0 (fp_usable && !fp64_en)[*3] |-> reserved_instr_q)
    else $error("long or paired format accepted without 64-bit mode");
  AST_UNUSABLE: assert property (
    fp ##0 !fp_usable[*3] |-> cop_unusable_q && !reserved_instr_q)
    else $error("inaccessible coprocessor not reported");
  AST_CMOV_FLAG_SEL: assert property (
    fp && sel inside {16, 17} && fn == fcd_pkg::FN_CMOV ##0 fp_usable[*3]
    |-> dec_class_q == fcd_pkg::FCD_CLS_CMOV && dec_flag_sel_q == $past(instr_word[16], 2))
    else $error("conditional move flag bit wrong");
  AST_SD_ARITH: assert property (
    fp && sel inside {16, 17} && fn < 8 ##0 fp_usable[*3]
    |-> dec_class_q == fcd_pkg::FCD_CLS_ARITH && dec_op_q == $past(fn, 2)
        && {2'b00, dec_fmt_q} == $past(sel, 2) - 5'h10)
    else $error("single or double arithmetic decoded wrongly");
  AST_CP2_ABSENT: assert property (
    instr_valid && opc == fcd_pkg::OPC_CP2 ##0 (cp2_usable && !cp2_present)[*3]
    |-> reserved_instr_q && !cop_unusable_q)
    else $error("absent second coprocessor not flagged");
endmodule
bind fcd_decoder fcd_decoder_chk u_chk (.sys_clk, .rst_b, .instr_word, .instr_valid,
  .fp64_en, .fp_usable, .cp2_usable, .cp2_present, .dec_valid_q, .dec_class_q,
  .dec_op_q, .dec_fmt_q, .dec_flag_sel_q, .reserved_instr_q, .cop_unusable_q);

// ==== tb_top.sv ====
// Self-checking bench comparing the decoder with a behavioural decode model.
`timescale 1ns/1ns
module tb_top;
  typedef struct {int v; int c; int o; int f; int t; int r; int u;} fcd_exp_s;
  logic              sys_clk, rst_b, fp64_en, fp_usable, cp2_usable, cp2_present;
  logic              instr_valid, dec_valid_q, dec_flag_sel_q, reserved_instr_q, cop_unusable_q;
  logic [31:0]       instr_word;
  logic [5:0]        dec_op_q;
  logic [3:0]        lv_q;
  fcd_pkg::fcd_cls_e dec_class_q;
  fcd_pkg::fcd_fmt_e dec_fmt_q;
  fcd_exp_s          p0, p1;
  int                err_count = 0, n_compared = 0, guard = 4;
  wire [3:0]         lv = {fp64_en, fp_usable, cp2_usable, cp2_present};

  fcd_fetch_model fetch (.sys_clk(sys_clk), .instr_word(instr_word), .instr_valid(instr_valid));
  fcd_decoder uut (.sys_clk(sys_clk), .rst_b(rst_b), .instr_word(instr_word),
    .instr_valid(instr_valid), .fp64_en(fp64_en), .fp_usable(fp_usable),
    .cp2_usable(cp2_usable), .cp2_present(cp2_present), .dec_valid_q(dec_valid_q),
    .dec_class_q(dec_class_q), .dec_op_q(dec_op_q), .dec_fmt_q(dec_fmt_q),
    .dec_flag_sel_q(dec_flag_sel_q), .reserved_instr_q(reserved_instr_q),
    .cop_unusable_q(cop_unusable_q));

  // A field the documented behaviour leaves open is modelled as -1 and skipped.
  function automatic fcd_exp_s model(logic [31:0] w, logic [3:0] l);
    fcd_exp_s e;
    int s = w[25:21];
    int fn = w[5:0];
    int k = fn % 8;
    e = '{1, -1, fn, -1, -1, 0, 0};
    if (w[31:26] == fcd_pkg::OPC_FP) begin
      if (s inside {16, 17, 22} && fn == 17) e = '{1, 6, w[16], s - 16, w[16], 0, 0};
      if (s < 16) begin
        e.o = s;
        if (s inside {0, 2, 3, 4, 6, 7, 8}) e.c = s == 8 ? 2 : 1;
        else e.r = 1;
      end else if (s < 18) begin
        e.f = s - 16;
        if (fn < 16) e.c = 3;
        else if (fn >= 48) e.c = 5;
        else if (fn != 17) e.r = 1;
        if (fn inside {8, 9, 10, 11} && !l[3]) e.r = 1;
      end else if (s inside {20, 21}) begin
        e.f = s - 16;
        if (fn inside {32, 33, 38}) e.c = 4;
        else e.r = 1;
        if (s == 21 && !l[3]) e.r = 1;
      end else if (s == 22) begin
        e.f = 6;
        if (fn inside {0, 1, 2, 5, 6, 7}) e.c = 3;
        else if (fn >= 48) e.c = 5;
        else if (fn inside {40, 44, 45, 46, 47}) e.c = 4;
        else if (!(fn inside {17, 40, 44, 45, 46, 47})) e.r = -1;
        if (!l[3]) e.r = 1;
      end else e.r = 1;
      if (!l[2]) e.u = 1;
    end else if (w[31:26] == fcd_pkg::OPC_FPX) begin
      if (fn inside {0, 1, 5, 8, 9, 13, 15}) e.c = fn == 15 ? 9 : fn < 8 ? 7 : 8;
      else if (fn >= 32 && k inside {0, 1, 6}) e.c = 10;
      else e.r = fn == 30 ? -1 : 1;
      e.f = k;
      if ((fn inside {5, 13} || (fn >= 32 && k == 6)) && !l[3]) e.r = 1;
      if (!l[2]) e.u = 1;
    end else if (w[31:26] == fcd_pkg::OPC_CP2) begin
      e.o = s;
      if (!l[0]) e.r = l[1] ? 1 : -1;
      else if (s inside {0, 2, 3, 4, 6, 7, 8} || s >= 16) e.c = s == 8 ? 2 : s > 8 ? 11 : 1;
      else e.r = 1;
      if (!l[1]) e.u = l[0] ? 1 : -1;
    end else e = '{0, 0, -1, -1, -1, 0, 0};
    if (e.u == 1) e.r = 0;
    if (e.u != 0 || e.r != 0) e.c = -1;
    if (!(e.c inside {3, 4, 5, 6, 10})) e.f = -1;
    if (e.c != 6) e.t = -1;
    if (e.c < 0) e.o = -1;
    return e;
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input int exp);
    if (exp >= 0) begin
      n_compared++;
      if (seen !== exp[7:0]) begin
        err_count++;
        $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Level inputs may be sampled at either pipeline stage, so compares pause after a change.
  always @(posedge sys_clk) begin
    guard <= lv != lv_q ? 4 : guard > 0 ? guard - 1 : 0;
    lv_q <= lv;
    p1 <= rst_b ? p0 : fcd_exp_s'{0, 0, 0, 0, 0, 0, 0};
    p0 <= !rst_b ? fcd_exp_s'{0, 0, 0, 0, 0, 0, 0} :
          instr_valid ? model(instr_word, lv) : fcd_exp_s'{0, -1, -1, -1, -1, 0, 0};
  end

  always @(negedge sys_clk) if (guard == 0) begin
    chk("valid", dec_valid_q, p1.v);
    chk("class", dec_class_q, p1.c);
    chk("op", dec_op_q, p1.o);
    chk("fmt", dec_fmt_q, p1.f);
    chk("flag_sel", dec_flag_sel_q, p1.t);
    chk("reserved", reserved_instr_q, p1.r);
    chk("unusable", cop_unusable_q, p1.u);
  end

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #(20 * 30000);
    err_count++;
    test_done();
  end

  initial begin
    logic [31:0] w;
    int          k;
    rst_b = 1'b0;
    {fp64_en, fp_usable, cp2_usable, cp2_present} = 4'hF;
    void'($urandom(32'h457E));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int m = 0; m < 6; m++) begin
      @(posedge sys_clk) fp64_en <= m[0];
      repeat (4) fetch.send(32'h0000_0000, 1'b0);
      for (int i = 0; i < 2048; i++)
        fetch.send({fcd_pkg::OPC_FP + 6'(m / 2), i[10:6], 15'($urandom), i[5:0]}, 1'b1);
    end
    $display("sweep of all selects and functions done");
    for (int b = 0; b < 60; b++) begin
      @(posedge sys_clk) {fp64_en, fp_usable, cp2_usable, cp2_present} <= 4'($urandom);
      rst_b <= b != 30;
      for (int i = 0; i < 64; i++) begin
        w = $urandom;
        k = $urandom % 4;
        if (k < 3) w[31:26] = fcd_pkg::OPC_FP + 6'(k);
        fetch.send(w, $urandom % 8 != 0);
      end
    end
    repeat (3) fetch.send(32'h0000_0000, 1'b0);
    $display("random words with changing enables done");
    test_done();
  end
endmodule
